// file: hdl/qps_bus_master.sv
// Master end: takes user commands through a buffer, frames them on SPI.
// Assumes the device shares ref_clk; serial clock made by a divider.
`timescale 1ns/100ps
module qps_bus_master
  import qps_pkg::*;
#(
  parameter int SCK_DIV   = QPS_SCK_DIV,
  parameter int NV_CYCLES = QPS_NV_CYCLES
)
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  // Serial link
  qps_link_if.host         link,
  // Command port
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [3:0]  cmd_op,
  input  wire logic [1:0]  cmd_addr,
  input  wire logic [1:0]  cmd_pot,
  input  wire logic [1:0]  cmd_idx,
  input  wire logic [7:0]  cmd_data,
  // Control levels
  input  wire logic        pause_req,
  input  wire logic        write_protect_n,
  // Read answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_data
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_LOW = 3'h1, H_HIGH = 3'h2, H_END = 3'h3, H_GAP = 3'h4
  } qps_host_state_type;
  localparam int DW = $clog2(SCK_DIV + 1);
  localparam int GW = $clog2(NV_CYCLES + 2);
  localparam logic [DW-1:0] DIV_LAST = DW'(SCK_DIV - 1);
  localparam logic [GW-1:0] NV_WAIT  = GW'(NV_CYCLES + 1);

  qps_host_state_type state_q;
  logic [17:0] buf_data;
  logic [23:0] tx_q;
  logic [7:0]  rx_q;
  logic [4:0]  cnt_q;
  logic [4:0]  nbits_q;
  logic [DW-1:0] div_q;
  logic [GW-1:0] gap_q;
  logic        tick;
  logic        buf_valid;
  logic        pop;
  logic        read_q;
  logic        nv_q;
  logic        cs_n_q, sck_q, si_q, hold_n_q, wp_n_q;
  qps_op_type  bop;

  // Two-entry command buffer; stalls while a frame is on the wire
  qps_pair_buffer #(.WIDTH(18), .DEPTH(2)) u_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   ({cmd_op, cmd_addr, cmd_pot, cmd_idx, cmd_data}),
    .out_valid (buf_valid),
    .out_ready (pop),
    .out_data  (buf_data)
  );

  assign bop = qps_op_type'(buf_data[17:14]);
  assign pop = (state_q == H_IDLE) & tick & buf_valid;

  ////////////////////////////////////////////////////////////////////////
  // Half-period enable divider
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_q <= '0;
    else
      div_q <= (div_q == DIV_LAST) ? '0 : div_q + DW'(1);
  end
  assign tick = (div_q == DIV_LAST);

  // Frame sequencer
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= H_IDLE;
      cs_n_q    <= 1'h1;
      sck_q     <= 1'h0;
      si_q      <= 1'h0;
      hold_n_q  <= 1'h1;
      wp_n_q    <= 1'h1;
      tx_q      <= '0;
      rx_q      <= '0;
      cnt_q     <= '0;
      nbits_q   <= '0;
      gap_q     <= '0;
      read_q    <= 1'h0;
      nv_q      <= 1'h0;
      rsp_valid <= 1'h0;
      rsp_data  <= '0;
    end
    else
    begin
      rsp_valid <= 1'h0;
      wp_n_q    <= write_protect_n;
      if (tick)
      begin
        case (state_q)
          H_IDLE:
          begin
            hold_n_q <= ~pause_req;
            if (buf_valid)
            begin
              tx_q <= {buf_data[17:10], 6'h00, buf_data[9:8],
                       (bop == QPS_OP_WR_WIPER || bop == QPS_OP_WR_SAVED)
                       ? buf_data[7:0] : 8'h00};
              si_q    <= buf_data[17];
              nbits_q <= (bop == QPS_OP_SAVE || bop == QPS_OP_RECALL)
                         ? QPS_BITS_SHORT : QPS_BITS_LONG;
              read_q  <= (bop == QPS_OP_RD_WIPER || bop == QPS_OP_RD_SAVED);
              nv_q    <= (bop == QPS_OP_WR_SAVED || bop == QPS_OP_SAVE);
              cnt_q   <= '0;
              cs_n_q  <= 1'h0;
              state_q <= H_LOW;
            end
          end
          H_LOW:
          begin
            hold_n_q <= ~pause_req;
            if (~pause_req & hold_n_q)
            begin
              sck_q   <= 1'h1;
              rx_q    <= {rx_q[6:0], link.so_line};
              cnt_q   <= cnt_q + 5'h01;
              state_q <= H_HIGH;
            end
          end
          H_HIGH:
          begin
            sck_q <= 1'h0;
            tx_q  <= {tx_q[22:0], 1'h0};
            si_q  <= tx_q[22];
            state_q <= (cnt_q == nbits_q) ? H_END : H_LOW;
          end
          H_END:
          begin
            cs_n_q    <= 1'h1;
            rsp_valid <= read_q;
            rsp_data  <= rx_q;
            gap_q     <= nv_q ? NV_WAIT : '0;
            state_q   <= H_GAP;
          end
          H_GAP:
          begin
            if (gap_q <= GW'(SCK_DIV))
              state_q <= H_IDLE;
            else
              gap_q <= gap_q - GW'(SCK_DIV);
          end
          default: state_q <= H_IDLE;
        endcase
      end
    end
  end

  assign link.cs_n   = cs_n_q;
  assign link.sck    = sck_q;
  assign link.si     = si_q;
  assign link.hold_n = hold_n_q;
  assign link.wp_n   = wp_n_q;
endmodule

// file: hdl/qps_link_if.sv
// Serial link between the bus master and the potentiometer device.
// Serial output line is pulled high when nobody drives it.
`timescale 1ns/100ps
interface qps_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so;
  logic so_oe_n;
  logic so_line;
  // Resolved serial output wire
  assign so_line = so_oe_n ? 1'h1 : so;
  modport dev (input cs_n, sck, si, hold_n, wp_n, output so, so_oe_n);
  modport host (output cs_n, sck, si, hold_n, wp_n, input so_line);
endinterface

// file: hdl/qps_pair_buffer.sv
// Small valid/ready buffer, two entries by default.
// Assumes one clock and asynchronous active-high reset.
`timescale 1ns/100ps
module qps_pair_buffer
  import qps_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      count_q;
  logic [PW:0]      count_d;
  logic             ready_q;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshakes
  assign push      = in_valid & ready_q;
  assign pop       = out_valid & out_ready;
  assign in_ready  = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_q];

  // Occupancy bookkeeping
  always_comb
  begin
    count_d = count_q;
    if (push & ~pop)
      count_d = count_q + (PW+1)'(1);
    else if (pop & ~push)
      count_d = count_q - (PW+1)'(1);
  end

  // Count and registered ready
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_q <= '0;
      ready_q <= 1'h1;
    end
    else
    begin
      count_q <= count_d;
      ready_q <= (count_d != FULL);
    end
  end

  // Storage and pointers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == LAST) ? '0 : wr_q + PW'(1);
      if (pop)
        rd_q <= (rd_q == LAST) ? '0 : rd_q + PW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end
endmodule

// file: hdl/qps_pkg.sv
// Shared constants for the quad potentiometer serial front end.
// Assumes both ends run from the same 10 MHz ref_clk.
package qps_pkg;
  localparam int QPS_POTS  = 4;
  localparam int QPS_SAVED = 4;
  localparam int QPS_WB    = 8;
  localparam int QPS_TAPS  = 256;
  // Opcode byte layout: op, device address, pot select
  localparam int QPS_OP_MSB  = 7;
  localparam int QPS_OP_LSB  = 4;
  localparam int QPS_ADR_MSB = 3;
  localparam int QPS_ADR_LSB = 2;
  localparam int QPS_POT_MSB = 1;
  localparam int QPS_POT_LSB = 0;
  localparam int QPS_IDX_MSB = 1;
  localparam int QPS_IDX_LSB = 0;
  localparam int QPS_BIT_LAST = 7;
  // Frame lengths in bits
  localparam logic [4:0] QPS_BITS_SHORT = 5'h10;
  localparam logic [4:0] QPS_BITS_LONG  = 5'h18;
  localparam logic [7:0] QPS_SAVED_INIT = 8'h80;
  typedef enum logic [3:0] {
    QPS_OP_RD_WIPER = 4'h1,
    QPS_OP_WR_WIPER = 4'h2,
    QPS_OP_RD_SAVED = 4'h3,
    QPS_OP_WR_SAVED = 4'h4,
    QPS_OP_SAVE     = 4'h5,
    QPS_OP_RECALL   = 4'h6
  } qps_op_type;
  // Timing
  localparam int QPS_CLK_NS      = 100;
  localparam int QPS_SCK_HALF_NS = 200;
  localparam int QPS_SCK_DIV     = QPS_SCK_HALF_NS / QPS_CLK_NS;
  localparam int QPS_NV_WRITE_NS = 10000;
  localparam int QPS_NV_CYCLES   = QPS_NV_WRITE_NS / QPS_CLK_NS;
endpackage

// file: hdl/qps_pot_device.sv
// Device end: serial command decoder, wiper and saved-setting store.
// Assumes link pins are synchronous to ref_clk; reset acts as power-up.
`timescale 1ns/100ps
module qps_pot_device
  import qps_pkg::*;
#(
  parameter int         NV_CYCLES  = QPS_NV_CYCLES,
  parameter logic [7:0] SAVED_INIT = QPS_SAVED_INIT
)
(
  // Clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               sys_rst,
  // Serial link
  qps_link_if.dev                                 link,
  // Identity straps
  input  wire logic                               device_addr_low_pin,
  input  wire logic                               device_addr_high_pin,
  // Potentiometer state
  output logic [QPS_POTS-1:0][QPS_WB-1:0]         wiper_setting_reg,
  output logic [QPS_POTS-1:0][QPS_TAPS-1:0]       tap_select,
  output logic                                    write_busy
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CMD   = 3'h1,
    ST_INDEX = 3'h2,
    ST_DATA  = 3'h3,
    ST_SKIP  = 3'h4
  } qps_dev_state_type;

  localparam int CW = $clog2(NV_CYCLES + 1);
  localparam logic [CW-1:0] NV_LAST = CW'(NV_CYCLES - 1);

  qps_dev_state_type state_q;
  logic [QPS_WB-1:0]  saved_q [QPS_POTS][QPS_SAVED];
  logic [QPS_WB-1:0]  wiper_q [QPS_POTS];
  logic [QPS_WB-1:0]  instr_q;
  logic [QPS_WB-1:0]  shift_q;
  logic [QPS_WB-1:0]  data_q;
  logic [QPS_WB-1:0]  out_sr_q;
  logic [QPS_WB-1:0]  byte_in;
  logic [2:0]         bit_q;
  logic [1:0]         idx_q;
  logic [1:0]         pot;
  logic [1:0]         my_addr;
  logic [CW-1:0]      nv_cnt_q;
  logic               sck_q;
  logic               cs_n_q;
  logic               wp_n_q;
  logic               busy_q;
  logic               recall_q;
  logic               reading_q;
  logic               pend_wiper_q;
  logic               pend_nv_q;
  logic               wp_cut_q;
  logic               so_q;
  logic               so_oe_n_q;
  logic               sck_rise;
  logic               sck_fall;
  logic               cs_rise;
  logic               cs_fall;
  logic               wp_fall;
  logic               active;
  logic               byte_done;
  logic               commit;
  logic               nv_start;
  qps_op_type         op;
  qps_op_type         new_op;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection on the link pins
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_q  <= 1'h0;
      cs_n_q <= 1'h1;
      wp_n_q <= 1'h1;
    end
    else
    begin
      sck_q  <= link.sck;
      cs_n_q <= link.cs_n;
      wp_n_q <= link.wp_n;
    end
  end

  assign sck_rise = link.sck & ~sck_q;
  assign sck_fall = ~link.sck & sck_q;
  assign cs_rise  = link.cs_n & ~cs_n_q;
  assign cs_fall  = ~link.cs_n & cs_n_q;
  assign wp_fall  = ~link.wp_n & wp_n_q;
  assign my_addr  = {device_addr_high_pin, device_addr_low_pin};
  // Selected, not paused and not busy writing
  assign active   = ~link.cs_n & link.hold_n & ~busy_q;
  assign byte_in  = {shift_q[QPS_WB-2:0], link.si};
  assign byte_done = active & sck_rise & (bit_q == 3'(QPS_BIT_LAST));
  assign op       = qps_op_type'(instr_q[QPS_OP_MSB:QPS_OP_LSB]);
  assign new_op   = qps_op_type'(byte_in[QPS_OP_MSB:QPS_OP_LSB]);
  assign pot      = instr_q[QPS_POT_MSB:QPS_POT_LSB];
  assign commit   = cs_rise & ~busy_q;
  assign nv_start = commit & pend_nv_q & link.wp_n;

  ////////////////////////////////////////////////////////////////////////
  // Bit shifter and instruction register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_q <= '0;
      bit_q   <= '0;
      instr_q <= '0;
      idx_q   <= '0;
      data_q  <= '0;
    end
    else if (cs_fall)
      bit_q <= '0;
    else if (active & sck_rise)
    begin
      shift_q <= byte_in;
      bit_q   <= bit_q + 3'h1;
      if (byte_done)
      begin
        case (state_q)
          ST_CMD:   instr_q <= byte_in;
          ST_INDEX: idx_q   <= byte_in[QPS_IDX_MSB:QPS_IDX_LSB];
          ST_DATA:  data_q  <= byte_in;
          default:  data_q  <= data_q;
        endcase
      end
    end
  end

  // Sequence position; a pause freezes it in place
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= ST_IDLE;
    else if (link.cs_n)
      state_q <= ST_IDLE;
    else if (cs_fall & ~busy_q)
      state_q <= ST_CMD;
    else if (byte_done)
    begin
      case (state_q)
        ST_CMD:
        begin
          if (byte_in[QPS_ADR_MSB:QPS_ADR_LSB] == my_addr &&
              new_op inside {QPS_OP_RD_WIPER, QPS_OP_WR_WIPER,
                             QPS_OP_RD_SAVED, QPS_OP_WR_SAVED,
                             QPS_OP_SAVE, QPS_OP_RECALL})
            state_q <= ST_INDEX;
          else
            state_q <= ST_SKIP;
        end
        ST_INDEX:
        begin
          if (op == QPS_OP_SAVE || op == QPS_OP_RECALL)
            state_q <= ST_SKIP;
          else
            state_q <= ST_DATA;
        end
        default: state_q <= ST_SKIP;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pending writes, armed only by a complete sequence
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pend_wiper_q <= 1'h0;
      pend_nv_q    <= 1'h0;
      wp_cut_q     <= 1'h0;
    end
    else
    begin
      if (cs_fall | commit)
      begin
        pend_wiper_q <= 1'h0;
        pend_nv_q    <= 1'h0;
      end
      // A protect fall anywhere in the frame blocks the saved write
      if (cs_fall)
        wp_cut_q <= 1'h0;
      if (wp_fall & ~link.cs_n)
      begin
        pend_nv_q <= 1'h0;
        wp_cut_q  <= 1'h1;
      end
      if (byte_done && state_q == ST_INDEX)
      begin
        pend_wiper_q <= (op == QPS_OP_RECALL);
        pend_nv_q    <= (op == QPS_OP_SAVE) & link.wp_n & ~wp_cut_q;
      end
      if (byte_done && state_q == ST_DATA)
      begin
        pend_wiper_q <= (op == QPS_OP_WR_WIPER);
        pend_nv_q    <= (op == QPS_OP_WR_SAVED) & link.wp_n & ~wp_cut_q;
      end
    end
  end

  // Nonvolatile write cycle timer, immune to protect once running
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q   <= 1'h0;
      nv_cnt_q <= '0;
    end
    else if (nv_start)
    begin
      busy_q   <= 1'h1;
      nv_cnt_q <= '0;
    end
    else if (busy_q)
    begin
      nv_cnt_q <= nv_cnt_q + CW'(1);
      if (nv_cnt_q == NV_LAST)
        busy_q <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Saved-setting store
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int p = 0; p < QPS_POTS; p++)
        for (int s = 0; s < QPS_SAVED; s++)
          saved_q[p][s] <= SAVED_INIT;
    end
    else if (nv_start)
      saved_q[pot][idx_q] <= (op == QPS_OP_WR_SAVED) ? data_q : wiper_q[pot];
  end

  // Wiper registers: recall after power-up, then serial updates
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      recall_q <= 1'h1;
      for (int p = 0; p < QPS_POTS; p++)
        wiper_q[p] <= '0;
    end
    else if (recall_q)
    begin
      recall_q <= 1'h0;
      for (int p = 0; p < QPS_POTS; p++)
        wiper_q[p] <= saved_q[p][0];
    end
    else if (commit & pend_wiper_q)
      wiper_q[pot] <= (op == QPS_OP_WR_WIPER) ? data_q : saved_q[pot][idx_q];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data shifter and serial output
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reading_q <= 1'h0;
      out_sr_q  <= '0;
      so_q      <= 1'h0;
      so_oe_n_q <= 1'h1;
    end
    else
    begin
      so_oe_n_q <= ~(reading_q & active);
      if (link.cs_n)
        reading_q <= 1'h0;
      else if (byte_done && state_q == ST_INDEX)
      begin
        reading_q <= (op == QPS_OP_RD_WIPER) || (op == QPS_OP_RD_SAVED);
        out_sr_q  <= (op == QPS_OP_RD_WIPER) ? wiper_q[pot]
                   : saved_q[pot][byte_in[QPS_IDX_MSB:QPS_IDX_LSB]];
      end
      else if (reading_q & active & sck_fall)
      begin
        so_q     <= out_sr_q[QPS_WB-1];
        out_sr_q <= {out_sr_q[QPS_WB-2:0], 1'h0};
      end
    end
  end

  assign link.so    = so_q;
  assign link.so_oe_n = so_oe_n_q;
  assign write_busy = busy_q;

  ////////////////////////////////////////////////////////////////////////
  // Registered wiper outputs and one-hot tap selection
  genvar gp;
  generate
    for (gp = 0; gp < QPS_POTS; gp++)
    begin : g_pot
      always_ff @(posedge ref_clk or posedge sys_rst)
      begin
        if (sys_rst)
        begin
          wiper_setting_reg[gp] <= '0;
          tap_select[gp]        <= QPS_TAPS'(1);
        end
        else
        begin
          wiper_setting_reg[gp] <= wiper_q[gp];
          tap_select[gp] <= QPS_TAPS'(1) << wiper_q[gp];
        end
      end
    end
  endgenerate
endmodule

// file: verification/qps_link_properties.sv
// Checker for the serial link between the master and device ends.
// Assumes one clock; instantiated beside the link interface.
`timescale 1ns/100ps
module qps_link_properties
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // Serial clock rises seen within the current frame
  logic       sck_q;
  logic [5:0] rise_cnt_q;
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sck_q      <= 1'h0;
      rise_cnt_q <= 6'h00;
    end
    else
    begin
      sck_q <= sck;
      if (cs_n)
        rise_cnt_q <= 6'h00;
      else if (sck && !sck_q)
        rise_cnt_q <= rise_cnt_q + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Wire behaviour of both ends
  sel_float_a: assert property (cs_n |=> so_oe_n)
    else $error("serial output driven while deselected");
  pause_float_a: assert property (!hold_n |=> so_oe_n)
    else $error("serial output driven while paused");
  so_on_fall_a: assert property ($changed(so) && !so_oe_n
    && $past(!so_oe_n) |-> $past(sck, 2) && !$past(sck))
    else $error("serial output moved without a clock fall");
  si_stable_a: assert property ($rose(sck) |-> $stable(si))
    else $error("serial input moved at a clock rise");
  hold_clk_low_a: assert property ($changed(hold_n) |-> !sck)
    else $error("pause changed with serial clock high");
  sel_clk_low_a: assert property ($fell(cs_n) |-> !sck)
    else $error("select fell with serial clock high");
  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("serial clock moving outside a frame");
  frame_len_a: assert property ($rose(cs_n)
    |-> rise_cnt_q inside {6'h10, 6'h18})
    else $error("frame has a wrong count of bits");
  drive_after_op_a: assert property (!so_oe_n
    |-> rise_cnt_q >= 6'h10)
    else $error("serial output driven inside the header");
  // Main scenarios
  cover property (!so_oe_n);
  cover property ($fell(hold_n));
  cover property ($rose(cs_n) && rise_cnt_q == 6'h10);
  cover property ($rose(cs_n) && rise_cnt_q == 6'h18);
endmodule

// file: verification/quad_pot_spi_front_end_tb.sv
// Bench joining the master end to the device end over the link.
// Assumes design files and checker are compiled before it.
`timescale 1ns/100ps
module quad_pot_spi_front_end_tb;
  import qps_pkg::*;
  localparam int         NV = 4;
  localparam logic [1:0] ME = 2'h2;
  logic                              ref_clk;
  logic                              sys_rst;
  logic                              cmd_valid;
  logic                              cmd_ready;
  logic [3:0]                        cmd_op;
  logic [1:0]                        cmd_addr;
  logic [1:0]                        cmd_pot;
  logic [1:0]                        cmd_idx;
  logic [7:0]                        cmd_data;
  logic                              pause_req;
  logic                              write_protect_n;
  logic                              rsp_valid;
  logic [7:0]                        rsp_data;
  logic [1:0]                        strap;
  logic [QPS_POTS-1:0][QPS_WB-1:0]   wiper;
  logic [QPS_POTS-1:0][QPS_TAPS-1:0] taps;
  logic                              busy;
  logic                              full_seen;
  logic [7:0]                        rd;
  int                                err_total;
  int                                compares;
  qps_link_if link ();
  ////////////////////////////////////////////////////////////////////////
  // Both ends and the checker
  qps_bus_master #(.SCK_DIV(QPS_SCK_DIV), .NV_CYCLES(NV))
  qps_bus_master_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_pot(cmd_pot),
    .cmd_idx(cmd_idx), .cmd_data(cmd_data), .pause_req(pause_req),
    .write_protect_n(write_protect_n), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));
  qps_pot_device #(.NV_CYCLES(NV))
  qps_pot_device_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .link(link), .device_addr_low_pin(strap[0]),
    .device_addr_high_pin(strap[1]), .wiper_setting_reg(wiper),
    .tap_select(taps), .write_busy(busy));
  qps_link_properties qps_link_properties_inst (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
    .hold_n(link.hold_n), .so(link.so), .so_oe_n(link.so_oe_n));
  ////////////////////////////////////////////////////////////////////////
  // Clock and buffer-full monitor
  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (sys_rst)
      full_seen <= 1'h0;
    else if (cmd_ready === 1'h0)
      full_seen <= 1'h1;
  ////////////////////////////////////////////////////////////////////////
  // Compare, command and wait helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [3:0] op, input logic [1:0] ad,
    input logic [1:0] pot, input logic [1:0] idx, input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_pot <= pot;
    cmd_idx <= idx;
    cmd_data <= dat;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (cmd_ready !== 1'h1 && n < 2000);
    if (cmd_ready !== 1'h1)
      err_total++;
    @(posedge ref_clk);
    cmd_valid <= 1'h0;
  endtask
  task automatic rd_cmd(input logic [3:0] op, input logic [1:0] pot,
    input logic [1:0] idx, output logic [7:0] v);
    int n;
    n = 0;
    send(op, ME, pot, idx, 8'h00);
    while (rsp_valid !== 1'h1 && n < 2000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (rsp_valid !== 1'h1)
      err_total++;
    v = rsp_data;
    @(posedge ref_clk);
  endtask
  // Select 0 waits on chip select, 1 on busy, 2 on output enable
  task automatic wait_lvl(input int sel, input logic v);
    int   n;
    logic s;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      s = (sel == 0) ? link.cs_n : (sel == 1) ? busy : link.so_oe_n;
      n++;
    end
    while (s !== v && n < 2000);
    if (s !== v)
      err_total++;
    @(posedge ref_clk);
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #(QPS_CLK_NS * 40000);
    err_total++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    sys_rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_op = 4'h0;
    cmd_addr = 2'h0;
    cmd_pot = 2'h0;
    cmd_idx = 2'h0;
    cmd_data = 8'h00;
    pause_req = 1'h0;
    write_protect_n = 1'h1;
    strap = ME;
    err_total = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'h0;
    for (int p = 0; p < QPS_POTS; p++)
    begin
      rd_cmd(QPS_OP_RD_WIPER, 2'(p), 2'h0, rd);
      check(rd, QPS_SAVED_INIT);
    end
    // Wiper write and tap choice
    send(QPS_OP_WR_WIPER, ME, 2'h1, 2'h0, 8'h5A);
    rd_cmd(QPS_OP_RD_WIPER, 2'h1, 2'h0, rd);
    check(rd, 8'h5A);
    check(wiper[1], 8'h5A);
    check({7'h00, taps[1][8'h5A]}, 8'h01);
    check(8'($countones(taps[1])), 8'h01);
    // Foreign address ignored
    send(QPS_OP_WR_WIPER, ~ME, 2'h0, 2'h0, 8'h22);
    rd_cmd(QPS_OP_RD_WIPER, 2'h0, 2'h0, rd);
    check(rd, QPS_SAVED_INIT);
    // Strap change moves the identity
    strap <= ~ME;
    send(QPS_OP_WR_WIPER, ~ME, 2'h0, 2'h0, 8'h22);
    wait_lvl(0, 1'h0);
    wait_lvl(0, 1'h1);
    repeat (2) @(posedge ref_clk);
    check(wiper[0], 8'h22);
    strap <= ME;
    // Saved write, recall and save
    send(QPS_OP_WR_SAVED, ME, 2'h2, 2'h3, 8'hC3);
    rd_cmd(QPS_OP_RD_SAVED, 2'h2, 2'h3, rd);
    check(rd, 8'hC3);
    send(QPS_OP_RECALL, ME, 2'h2, 2'h3, 8'h00);
    rd_cmd(QPS_OP_RD_WIPER, 2'h2, 2'h0, rd);
    check(rd, 8'hC3);
    send(QPS_OP_SAVE, ME, 2'h1, 2'h1, 8'h00);
    rd_cmd(QPS_OP_RD_SAVED, 2'h1, 2'h1, rd);
    check(rd, 8'h5A);
    // Protect low: saved write dropped, wiper write kept
    write_protect_n <= 1'h0;
    send(QPS_OP_WR_SAVED, ME, 2'h0, 2'h1, 8'h11);
    send(QPS_OP_WR_WIPER, ME, 2'h3, 2'h0, 8'h3F);
    rd_cmd(QPS_OP_RD_SAVED, 2'h0, 2'h1, rd);
    check(rd, QPS_SAVED_INIT);
    rd_cmd(QPS_OP_RD_WIPER, 2'h3, 2'h0, rd);
    check(rd, 8'h3F);
    write_protect_n <= 1'h1;
    // Protect pulses low inside the frame: write aborted
    send(QPS_OP_WR_SAVED, ME, 2'h3, 2'h2, 8'h77);
    wait_lvl(0, 1'h0);
    repeat (10) @(posedge ref_clk);
    write_protect_n <= 1'h0;
    repeat (10) @(posedge ref_clk);
    write_protect_n <= 1'h1;
    wait_lvl(0, 1'h1);
    rd_cmd(QPS_OP_RD_SAVED, 2'h3, 2'h2, rd);
    check(rd, QPS_SAVED_INIT);
    // Protect falls during the write cycle: write completes
    send(QPS_OP_WR_SAVED, ME, 2'h0, 2'h2, 8'h3C);
    wait_lvl(1, 1'h1);
    write_protect_n <= 1'h0;
    wait_lvl(1, 1'h0);
    write_protect_n <= 1'h1;
    rd_cmd(QPS_OP_RD_SAVED, 2'h0, 2'h2, rd);
    check(rd, 8'h3C);
    // Pause in the middle of a read reply
    fork
      rd_cmd(QPS_OP_RD_WIPER, 2'h1, 2'h0, rd);
      begin
        wait_lvl(2, 1'h0);
        repeat (3) @(posedge ref_clk);
        pause_req <= 1'h1;
        repeat (30) @(posedge ref_clk);
        check({7'h00, link.so_oe_n}, 8'h01);
        pause_req <= 1'h0;
      end
    join
    check(rd, 8'h5A);
    // Back-to-back writes fill the two-entry buffer
    for (int i = 0; i < 3; i++)
      send(QPS_OP_WR_WIPER, ME, 2'(i), 2'h0, 8'(8'h10 + i));
    rd_cmd(QPS_OP_RD_WIPER, 2'h2, 2'h0, rd);
    check(rd, 8'h12);
    check({7'h00, full_seen}, 8'h01);
    final_report();
  end
endmodule
